// file: src/lls_pkg.sv
// shared constants for the lane link health register slice
package lls_pkg;

    localparam int NUM_LINKS  = 2;
    localparam int NUM_LANES  = 3;
    localparam int FIRST_LANE = 5;
    localparam int ADDR_W     = 12;
    localparam int DATA_W     = 8;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_LINK_PAGE   = 12'h300;
    localparam logic [ADDR_W-1:0] ADDR_LANE5       = 12'h4B5;
    localparam logic [ADDR_W-1:0] ADDR_LANE6       = 12'h4B6;
    localparam logic [ADDR_W-1:0] ADDR_LANE7       = 12'h4B7;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN_A    = 12'h4B8;

    ////////////////////////////////////////////////////////////////////////
    // field positions: lane health and irq enable share bits 7..3, link page uses bit 0
    localparam int BIT_BAD_DISP    = 7;
    localparam int BIT_NOT_IN_TBL  = 6;
    localparam int BIT_UNEXP_CTRL  = 5;
    localparam int BIT_DESKEW      = 4;
    localparam int BIT_INIT_ALIGN  = 3;
    localparam int BIT_CHECKSUM    = 2;
    localparam int BIT_FRAME_SYNC  = 1;
    localparam int BIT_CODE_GROUP  = 0;
    localparam int BIT_LINK_PAGE   = 0;

    ////////////////////////////////////////////////////////////////////////
    // masks and reset values
    localparam logic [DATA_W-1:0] IRQ_EN_MASK      = 8'hF8;
    localparam logic [DATA_W-1:0] EVENT_MASK       = 8'hF8;
    localparam logic [DATA_W-1:0] LINK_PAGE_MASK   = 8'h01;
    localparam logic [DATA_W-1:0] HEALTH_RESET     = 8'h00;
    localparam logic [DATA_W-1:0] IRQ_EN_RESET     = 8'h00;
    localparam logic [DATA_W-1:0] LINK_PAGE_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO        = 8'h00;

endpackage

// file: src/lls_lane_health.sv
// one lane's health flags, registered, with change events
`timescale 1ns/1ps
module lls_lane_health
(
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic [lls_pkg::DATA_W-1:0] errorThreshold,
    input  wire logic [lls_pkg::DATA_W-1:0] badDispCount,
    input  wire logic [lls_pkg::DATA_W-1:0] notInTableCount,
    input  wire logic [lls_pkg::DATA_W-1:0] unexpCtrlCount,
    input  wire logic                      deskewOk,
    input  wire logic                      initialAlignOk,
    input  wire logic                      checksumOk,
    input  wire logic                      frameSync,
    input  wire logic                      codeGroupSync,
    output logic      [lls_pkg::DATA_W-1:0] health,
    output logic      [lls_pkg::DATA_W-1:0] healthEvent
);

    logic [lls_pkg::DATA_W-1:0] next_health;
    logic [lls_pkg::DATA_W-1:0] next_healthEvent;

    always_comb
    begin
        next_health = lls_pkg::HEALTH_RESET;
        next_health[lls_pkg::BIT_BAD_DISP]   =
            (badDispCount >= errorThreshold);
        next_health[lls_pkg::BIT_NOT_IN_TBL] =
            (notInTableCount >= errorThreshold);
        next_health[lls_pkg::BIT_UNEXP_CTRL] =
            (unexpCtrlCount >= errorThreshold);
        next_health[lls_pkg::BIT_DESKEW]     = deskewOk;
        next_health[lls_pkg::BIT_INIT_ALIGN] = initialAlignOk;
        next_health[lls_pkg::BIT_CHECKSUM]   = checksumOk;
        next_health[lls_pkg::BIT_FRAME_SYNC] = frameSync;
        next_health[lls_pkg::BIT_CODE_GROUP] = codeGroupSync;
        // error flags count only on rising, sync flags on any change
        next_healthEvent = next_health ^ health;
        next_healthEvent[lls_pkg::BIT_BAD_DISP] =
            next_health[lls_pkg::BIT_BAD_DISP]
            & ~health[lls_pkg::BIT_BAD_DISP];
        next_healthEvent[lls_pkg::BIT_NOT_IN_TBL] =
            next_health[lls_pkg::BIT_NOT_IN_TBL]
            & ~health[lls_pkg::BIT_NOT_IN_TBL];
        next_healthEvent[lls_pkg::BIT_UNEXP_CTRL] =
            next_health[lls_pkg::BIT_UNEXP_CTRL]
            & ~health[lls_pkg::BIT_UNEXP_CTRL];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            health      <= lls_pkg::HEALTH_RESET;
            healthEvent <= lls_pkg::HEALTH_RESET;
        end
        else
        begin
            health      <= next_health;
            healthEvent <= next_healthEvent;
        end
    end

endmodule

// file: src/lls_irq_enable_bank.sv
// per-link copies of the first irq enable register
`timescale 1ns/1ps
module lls_irq_enable_bank
(
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic                        wrEn,
    input  wire logic                        wrLink,
    input  wire logic [lls_pkg::DATA_W-1:0]   wrData,
    output logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::DATA_W-1:0] enables
);

    logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::DATA_W-1:0] next_enables;

    always_comb
    begin
        next_enables = enables;
        if (wrEn)
        begin
            // only bits 7..3 live here; the rest read zero
            next_enables[wrLink] = wrData & lls_pkg::IRQ_EN_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            enables <= {lls_pkg::NUM_LINKS{lls_pkg::IRQ_EN_RESET}};
        end
        else
        begin
            enables <= next_enables;
        end
    end

endmodule

// file: src/lls_link_health_regs.sv
// lane 5..7 link health and first irq enable registers, paged per link
// Function
// - bad disparity flag set when count reaches threshold
// - not-in-table flag set when count reaches threshold
// - unexpected control flag set at count reaching threshold
// - bit 4 shows lane deskew achieved
// - bit 3 shows initial lane alignment achieved
// - bit 2 shows lane checksum correct
// - bit 1 shows frame synchronization achieved
// - bit 0 shows code group synchronization achieved
// - link page selects which link copy is accessed
// - bit 7 enables bad disparity interrupts, resets 0
// - bit 6 enables not-in-table interrupts, resets 0
// - bit 5 enables unexpected control interrupts, resets 0
// - bit 4 enables deskew interrupts, resets 0
// - bit 3 enables initial alignment interrupts, resets 0
// - lane status bits read-only, reset zero
`timescale 1ns/1ps
module lls_link_health_regs
(
    input  wire logic                                   clk,
    input  wire logic                                   rst_b,
    input  wire logic [lls_pkg::ADDR_W-1:0]              regAddr,
    input  wire logic                                   regWrEn,
    input  wire logic                                   regRdEn,
    input  wire logic [lls_pkg::DATA_W-1:0]              regWrData,
    output logic      [lls_pkg::DATA_W-1:0]              regRdData,
    input  wire logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::DATA_W-1:0]
                                                        errorThreshold,
    input  wire logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::NUM_LANES-1:0]
                      [lls_pkg::DATA_W-1:0]             badDispCount,
    input  wire logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::NUM_LANES-1:0]
                      [lls_pkg::DATA_W-1:0]             notInTableCount,
    input  wire logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::NUM_LANES-1:0]
                      [lls_pkg::DATA_W-1:0]             unexpCtrlCount,
    input  wire logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::NUM_LANES-1:0]
                                                        deskewOk,
    input  wire logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::NUM_LANES-1:0]
                                                        initialAlignOk,
    input  wire logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::NUM_LANES-1:0]
                                                        checksumOk,
    input  wire logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::NUM_LANES-1:0]
                                                        frameSync,
    input  wire logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::NUM_LANES-1:0]
                                                        codeGroupSync,
    output logic      [lls_pkg::NUM_LINKS-1:0]           irqReq
);

    ////////////////////////////////////////////////////////////////////////
    // per-lane health, one instance per link and lane

    logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::NUM_LANES-1:0]
          [lls_pkg::DATA_W-1:0] health;
    logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::NUM_LANES-1:0]
          [lls_pkg::DATA_W-1:0] healthEvent;

    for (genvar lk = 0; lk < lls_pkg::NUM_LINKS; lk++)
    begin : g_link
        for (genvar ln = 0; ln < lls_pkg::NUM_LANES; ln++)
        begin : g_lane
            lls_lane_health u_lane
            (
                .clk             (clk),
                .rst_b           (rst_b),
                .errorThreshold  (errorThreshold[lk]),
                .badDispCount    (badDispCount[lk][ln]),
                .notInTableCount (notInTableCount[lk][ln]),
                .unexpCtrlCount  (unexpCtrlCount[lk][ln]),
                .deskewOk        (deskewOk[lk][ln]),
                .initialAlignOk  (initialAlignOk[lk][ln]),
                .checksumOk      (checksumOk[lk][ln]),
                .frameSync       (frameSync[lk][ln]),
                .codeGroupSync   (codeGroupSync[lk][ln]),
                .health          (health[lk][ln]),
                .healthEvent     (healthEvent[lk][ln])
            );
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link page selector

    logic [lls_pkg::DATA_W-1:0] linkPage;
    logic [lls_pkg::DATA_W-1:0] next_linkPage;
    logic                       pageSel;

    always_comb
    begin
        next_linkPage = linkPage;
        if (regWrEn && regAddr == lls_pkg::ADDR_LINK_PAGE)
        begin
            next_linkPage = regWrData & lls_pkg::LINK_PAGE_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            linkPage <= lls_pkg::LINK_PAGE_RESET;
        end
        else
        begin
            linkPage <= next_linkPage;
        end
    end

    assign pageSel = linkPage[lls_pkg::BIT_LINK_PAGE];

    ////////////////////////////////////////////////////////////////////////
    // irq enables, one copy per link

    logic [lls_pkg::NUM_LINKS-1:0][lls_pkg::DATA_W-1:0] irqEnable;
    logic                                             enWr;

    // writes to the status registers fall through: they hold no storage
    assign enWr = regWrEn && regAddr == lls_pkg::ADDR_IRQ_EN_A;

    lls_irq_enable_bank u_enables
    (
        .clk     (clk),
        .rst_b   (rst_b),
        .wrEn    (enWr),
        .wrLink  (pageSel),
        .wrData  (regWrData),
        .enables (irqEnable)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupt request, one-cycle pulse per link

    logic [lls_pkg::NUM_LINKS-1:0] next_irqReq;

    always_comb
    begin
        next_irqReq = '0;
        for (int lk = 0; lk < lls_pkg::NUM_LINKS; lk++)
        begin
            for (int ln = 0; ln < lls_pkg::NUM_LANES; ln++)
            begin
                // masked conditions are dropped, not held pending
                if ((healthEvent[lk][ln] & irqEnable[lk]
                     & lls_pkg::EVENT_MASK) != lls_pkg::READ_ZERO)
                begin
                    next_irqReq[lk] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irqReq <= '0;
        end
        else
        begin
            irqReq <= next_irqReq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, data registered one cycle after the strobe

    logic [lls_pkg::DATA_W-1:0] next_regRdData;

    always_comb
    begin
        next_regRdData = regRdData;
        if (regRdEn)
        begin
            case (regAddr)
                lls_pkg::ADDR_LINK_PAGE:
                    next_regRdData = linkPage;
                lls_pkg::ADDR_LANE5:
                    next_regRdData = health[pageSel][0];
                lls_pkg::ADDR_LANE6:
                    next_regRdData = health[pageSel][1];
                lls_pkg::ADDR_LANE7:
                    next_regRdData = health[pageSel][2];
                lls_pkg::ADDR_IRQ_EN_A:
                    next_regRdData = irqEnable[pageSel];
                default:
                    next_regRdData = lls_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regRdData <= lls_pkg::READ_ZERO;
        end
        else
        begin
            regRdData <= next_regRdData;
        end
    end

endmodule

// file: tb/lls_link_health_regs_chk.sv
// assertion checker for the lane link health register slice
`timescale 1ns/1ps
module lls_link_health_regs_chk
(
    input wire logic                   clk,
    input wire logic                   rst_b,
    input wire logic [11:0]            regAddr,
    input wire logic                   regWrEn,
    input wire logic                   regRdEn,
    input wire logic [7:0]             regWrData,
    input wire logic [7:0]             regRdData,
    input wire logic [1:0][7:0]        errorThreshold,
    input wire logic [1:0][2:0][7:0]   badDispCount,
    input wire logic [1:0][2:0][7:0]   notInTableCount,
    input wire logic [1:0][2:0][7:0]   unexpCtrlCount,
    input wire logic [1:0][2:0]        deskewOk,
    input wire logic [1:0][2:0]        initialAlignOk,
    input wire logic [1:0][2:0]        checksumOk,
    input wire logic [1:0][2:0]        frameSync,
    input wire logic [1:0][2:0]        codeGroupSync,
    input wire logic [1:0]             irqReq
);
    ////////////////////////////////////////////////////////////////////////
    // shadow of page and enables, expected health of the paged link
    logic             pg;
    logic [1:0][7:0]  en;
    logic [2:0][7:0]  hExp;
    logic [1:0]       lane;
    logic             isLane;
    logic [7:0]       th;
    assign th     = errorThreshold[pg];
    assign lane   = 2'(regAddr - lls_pkg::ADDR_LANE5);
    assign isLane = regAddr >= lls_pkg::ADDR_LANE5
                    && regAddr <= lls_pkg::ADDR_LANE7;
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            hExp[i] = {badDispCount[pg][i] >= th,
                       notInTableCount[pg][i] >= th,
                       unexpCtrlCount[pg][i] >= th, deskewOk[pg][i],
                       initialAlignOk[pg][i], checksumOk[pg][i],
                       frameSync[pg][i], codeGroupSync[pg][i]};
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pg <= 1'b0;
            en <= '0;
        end
        else if (regWrEn && regAddr == lls_pkg::ADDR_LINK_PAGE)
            pg <= regWrData[0];
        else if (regWrEn && regAddr == lls_pkg::ADDR_IRQ_EN_A)
            en[pg] <= regWrData & lls_pkg::IRQ_EN_MASK;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // first read after reset still sees reset health, so it is skipped
    property p_err_flags;
        regRdEn && isLane && $past(rst_b) && $stable(hExp)
        |=> regRdData[7:5] == $past(hExp[lane][7:5]);
    endproperty
    a_err_flags: assert property (p_err_flags)
        else $error("error flag read wrong");
    property p_status;
        regRdEn && isLane && $past(rst_b) && $stable(hExp)
        |=> regRdData[4:0] == $past(hExp[lane][4:0]);
    endproperty
    a_status: assert property (p_status)
        else $error("status bit read wrong");
    property p_en_rd;
        regRdEn && regAddr == lls_pkg::ADDR_IRQ_EN_A
        |=> regRdData == $past(en[pg]);
    endproperty
    a_en_rd: assert property (p_en_rd)
        else $error("irq enable read wrong");
    property p_page_rd;
        regRdEn && regAddr == lls_pkg::ADDR_LINK_PAGE
        |=> regRdData == {7'h00, $past(pg)};
    endproperty
    a_page_rd: assert property (p_page_rd)
        else $error("link page read wrong");
    property p_unmapped;
        regRdEn && !isLane && regAddr != lls_pkg::ADDR_IRQ_EN_A
        && regAddr != lls_pkg::ADDR_LINK_PAGE |=> regRdData == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rd_hold;
        !regRdEn |=> $stable(regRdData);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without read");
    property p_irq0;
        irqReq[0] |-> $past(en[0]) != 8'h00;
    endproperty
    a_irq0: assert property (p_irq0)
        else $error("link 0 irq with no enable");
    property p_irq1;
        irqReq[1] |-> $past(en[1]) != 8'h00;
    endproperty
    a_irq1: assert property (p_irq1)
        else $error("link 1 irq with no enable");
    c_irq0: cover property (irqReq[0]);
    c_irq1: cover property (irqReq[1]);
    c_lane: cover property (regRdEn && isLane && pg);
endmodule

bind lls_link_health_regs lls_link_health_regs_chk u_chk
(
    .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .errorThreshold(errorThreshold), .badDispCount(badDispCount),
    .notInTableCount(notInTableCount), .unexpCtrlCount(unexpCtrlCount),
    .deskewOk(deskewOk), .initialAlignOk(initialAlignOk),
    .checksumOk(checksumOk), .frameSync(frameSync),
    .codeGroupSync(codeGroupSync), .irqReq(irqReq)
);

// file: tb/lls_link_health_regs_tb.sv
// self-checking bench for the lane link health register slice
`timescale 1ns/1ps
module lls_link_health_regs_tb;
    logic                   clk = 0, rst_b = 0;
    logic                   regWrEn = 0, regRdEn = 0;
    logic [11:0]            regAddr = '0;
    logic [7:0]             regWrData = '0, regRdData;
    logic [1:0][7:0]        errorThreshold = {8'h21, 8'h10};
    logic [1:0][2:0][7:0]   badDispCount = '0, notInTableCount = '0;
    logic [1:0][2:0][7:0]   unexpCtrlCount = '0;
    logic [1:0][2:0]        deskewOk = '0, initialAlignOk = '0;
    logic [1:0][2:0]        checksumOk = '0, frameSync = '0;
    logic [1:0][2:0]        codeGroupSync = '0;
    logic [1:0]             irqReq;
    int                     badCount = 0, checked = 0;
    int                     irqCnt [2];
    always #25 clk = ~clk;
    always @(posedge clk)
        for (int l = 0; l < 2; l++)
            if (irqReq[l] === 1'b1)
                irqCnt[l]++;
    lls_link_health_regs u_dut
    (
        .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
        .errorThreshold(errorThreshold), .badDispCount(badDispCount),
        .notInTableCount(notInTableCount), .unexpCtrlCount(unexpCtrlCount),
        .deskewOk(deskewOk), .initialAlignOk(initialAlignOk),
        .checksumOk(checksumOk), .frameSync(frameSync),
        .codeGroupSync(codeGroupSync), .irqReq(irqReq)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            badCount++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask
    // data lands on the edge after the strobe, so look one negedge on
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        chk(regRdData, e);
    endtask
    task automatic clr();
        {badDispCount, notInTableCount, unexpCtrlCount} = '0;
        {deskewOk, initialAlignOk, checksumOk, frameSync} = '0;
        codeGroupSync = '0;
    endtask
    task automatic set_bit(input int l, input int i, input int b,
                           input logic [7:0] cnt);
        case (b)
            7: badDispCount[l][i] = cnt;
            6: notInTableCount[l][i] = cnt;
            5: unexpCtrlCount[l][i] = cnt;
            4: deskewOk[l][i] = 1'b1;
            3: initialAlignOk[l][i] = 1'b1;
            2: checksumOk[l][i] = 1'b1;
            1: frameSync[l][i] = 1'b1;
            default: codeGroupSync[l][i] = 1'b1;
        endcase
    endtask
    // one event on link b[0]; six cycles cover the two-cycle irq latency
    task automatic irq_try(input int b, input logic [7:0] en,
                           input logic [7:0] exp);
        wr(lls_pkg::ADDR_LINK_PAGE, 8'(b % 2));
        wr(lls_pkg::ADDR_IRQ_EN_A, en);
        @(negedge clk);
        irqCnt = '{0, 0};
        set_bit(b % 2, b % 3, b, errorThreshold[b % 2]);
        repeat (6) @(negedge clk);
        chk(8'(irqCnt[b % 2]), exp);
        clr();
        repeat (6) @(negedge clk);
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [11:0] ad;
        logic [7:0]  ex;
        irqCnt = '{0, 0};
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        rd(lls_pkg::ADDR_LINK_PAGE, 8'h00);
        rd(lls_pkg::ADDR_IRQ_EN_A, 8'h00);
        for (int i = 0; i < 3; i++)
            rd(lls_pkg::ADDR_LANE5 + 12'(i), 8'h00);
        wr(lls_pkg::ADDR_IRQ_EN_A, 8'hFF);
        rd(lls_pkg::ADDR_IRQ_EN_A, 8'hF8);
        wr(lls_pkg::ADDR_LINK_PAGE, 8'hFF);
        rd(lls_pkg::ADDR_LINK_PAGE, 8'h01);
        rd(lls_pkg::ADDR_IRQ_EN_A, 8'h00);
        wr(lls_pkg::ADDR_IRQ_EN_A, 8'h0F);
        rd(lls_pkg::ADDR_IRQ_EN_A, 8'h08);
        wr(lls_pkg::ADDR_IRQ_EN_A, 8'h00);
        wr(lls_pkg::ADDR_LINK_PAGE, 8'h00);
        rd(lls_pkg::ADDR_IRQ_EN_A, 8'hF8);
        wr(lls_pkg::ADDR_LANE6, 8'hFF);
        rd(lls_pkg::ADDR_LANE6, 8'h00);
        rd(12'h04B9, 8'h00);
        wr(lls_pkg::ADDR_IRQ_EN_A, 8'h00);
        $display("register access test done");
        // each flag alone, count one below and at threshold, both pages
        for (int l = 0; l < 2; l++)
            for (int i = 0; i < 3; i++)
                for (int b = 0; b < 8; b++)
                    for (int v = 0; v < 2; v++)
                    begin
                        clr();
                        set_bit(l, i, b, errorThreshold[l] - 8'h01 + 8'(v));
                        wr(lls_pkg::ADDR_LINK_PAGE, 8'(l));
                        ad = lls_pkg::ADDR_LANE5 + 12'(i);
                        ex = (b < 5 || v == 1) ? 8'(1 << b) : 8'h00;
                        if (b < 5)
                            rd(ad, ex);
                        else
                            rd(ad, ex);
                        wr(lls_pkg::ADDR_LINK_PAGE, 8'(1 - l));
                        rd(ad, 8'h00);
                    end
        clr();
        chk(8'(irqCnt[0] + irqCnt[1]), 8'h00);
        $display("health field test done");
        for (int b = 3; b < 8; b++)
        begin
            irq_try(b, 8'(1 << b), 8'h01);
            irq_try(b, 8'hF8 & ~8'(1 << b), 8'h00);
        end
        irq_try(2, 8'hF8, 8'h00);
        $display("irq enable test done");
        final_report();
    end
endmodule
